//--- ssm_regs.svh
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// Data SRAM of 2KB held as 16-bit words
`define SSM_SRAM_WORDS   1024
`define SSM_SP_W         10
`define SSM_SP_TOP       10'h3FF
// Utility ROM: 1.5KB = 768 words from 8000h
`define SSM_ROM_BASE     16'h8000
`define SSM_ROM_WORDS    16'h0300
`define SSM_USER_START   16'h0000
`define SSM_NUM_DP       3
`define SSM_NUM_ACC      16
`define SSM_STEP_NONE    2'h0
`define SSM_STEP_INC     2'h1
`define SSM_STEP_DEC     2'h2

`endif

//--- ssm_pkg.sv
`default_nettype none
`include "ssm_regs.svh"
package ssm_pkg;

  typedef enum logic [2:0] {
    SSM_OP_NONE, SSM_OP_CALL, SSM_OP_RET, SSM_OP_RETURN_FROM_INTERRUPT, SSM_OP_INT,
    SSM_OP_PUSH, SSM_OP_POP, SSM_OP_POP_WITH_INTERRUPT_REENABLE
  } ssm_op_t;

  typedef enum logic {SSM_BOOT, SSM_RUN} ssm_boot_t;

  typedef struct packed {
    ssm_boot_t                                   boot;
    logic [15:0]                                 pc;
    logic                                        rom_sel;
    logic [`SSM_SP_W-1:0]                        sp;
    logic [15:0]                                 pop_data;
    logic                                        reen;
    logic [`SSM_NUM_DP-1:0][15:0]                dp;
    logic [15:0]                                 rdata;
    logic [`SSM_NUM_ACC-1:0][15:0]               acc;
    logic [15:0]                                 acc_rdata;
    logic [`SSM_SRAM_WORDS-1:0][15:0]            mem;
  } ssm_state_t;

endpackage
`default_nettype wire

//--- ssm_core.sv
// Functional notes
// - Stack lives in the shared 2KB data SRAM, no separate storage.
// - Software sets stack placement by loading the stack pointer.
// - Reset puts the stack pointer at the highest SRAM word.
// - Each store onto the stack decrements the stack pointer.
// - Each removal from the stack increments the stack pointer.
// - Call, return, interrupt return and interrupt entry save or restore return address.
// - Push, pop and interrupt-reenabling pop move arbitrary values via the stack.
// - Utility ROM spans 1.5KB of program space from 8000h.
// - Separate 16-bit program and data address buses; data in bytes or words.
// - Data accesses go through data pointers with automatic increment or decrement.
// - Sixteen 16-bit working registers next to the ALU.
// - Fetch starts at 8000h after reset, then jumps to 0000h unless test mode.
`timescale 1ns/1ps
`default_nettype none
`include "ssm_regs.svh"
module ssm_core (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire ssm_pkg::ssm_op_t op,
  input  wire logic [15:0]     target,
  input  wire logic [15:0]     int_vector,
  input  wire logic [15:0]     push_data,
  input  wire logic            sp_load,
  input  wire logic [15:0]     sp_wdata,
  input  wire logic            pc_advance,
  input  wire logic            test_mode,
  input  wire logic [1:0]      dp_sel,
  input  wire logic            dp_load,
  input  wire logic [15:0]     dp_wval,
  input  wire logic            dp_rd,
  input  wire logic            dp_wr,
  input  wire logic            byte_mode,
  input  wire logic [15:0]     dp_wdata,
  input  wire logic [1:0]      dp_step,
  input  wire logic            acc_we,
  input  wire logic [3:0]      acc_widx,
  input  wire logic [15:0]     acc_wdata,
  input  wire logic [3:0]      acc_ridx,
  output logic [`SSM_SP_W-1:0] stack_top_pointer,
  output logic [15:0]          prog_addr,
  output logic                 rom_sel,
  output logic [15:0]          pop_data,
  output logic                 pop_with_interrupt_reenable,
  output logic [15:0]          data_addr,
  output logic [15:0]          data_rdata,
  output logic [15:0]          acc_rdata
);

  ssm_pkg::ssm_state_t s;
  ssm_pkg::ssm_state_t next_s;

  function automatic logic in_rom(input logic [15:0] a);
    in_rom = (a >= `SSM_ROM_BASE) && (a < 16'(`SSM_ROM_BASE + `SSM_ROM_WORDS));
  endfunction

  function automatic logic [`SSM_SP_W-1:0] word_idx(input logic [15:0] a, input logic bm);
    word_idx = bm ? a[`SSM_SP_W:1] : a[`SSM_SP_W-1:0];
  endfunction

  logic [`SSM_SP_W-1:0] sp_up;
  logic [15:0]          dpa;
  logic [`SSM_SP_W-1:0] wi;
  logic [15:0]          wword;
  logic                 boot_step;

  always_comb begin
    next_s = s;
    sp_up = `SSM_SP_W'(s.sp + 1'b1);
    dpa = s.dp[dp_sel];
    wi = word_idx(dpa, byte_mode);
    wword = s.mem[wi];
    if (ce) begin
      // Pulse clears only on an enabled cycle, so a frozen core holds it
      next_s.reen = 1'b0;
      // Stack is just a region of the shared data words
      case (op)
        ssm_pkg::SSM_OP_CALL: begin
          next_s.mem[s.sp] = 16'(s.pc + 16'h0001);
          next_s.sp = `SSM_SP_W'(s.sp - 1'b1);
          next_s.pc = target;
        end
        ssm_pkg::SSM_OP_INT: begin
          next_s.mem[s.sp] = s.pc;
          next_s.sp = `SSM_SP_W'(s.sp - 1'b1);
          next_s.pc = int_vector;
        end
        ssm_pkg::SSM_OP_PUSH: begin
          next_s.mem[s.sp] = push_data;
          next_s.sp = `SSM_SP_W'(s.sp - 1'b1);
        end
        ssm_pkg::SSM_OP_RET, ssm_pkg::SSM_OP_RETURN_FROM_INTERRUPT: begin
          next_s.sp = sp_up;
          next_s.pc = s.mem[sp_up];
          next_s.reen = (op == ssm_pkg::SSM_OP_RETURN_FROM_INTERRUPT);
        end
        ssm_pkg::SSM_OP_POP, ssm_pkg::SSM_OP_POP_WITH_INTERRUPT_REENABLE: begin
          next_s.sp = sp_up;
          next_s.pop_data = s.mem[sp_up];
          next_s.reen = (op == ssm_pkg::SSM_OP_POP_WITH_INTERRUPT_REENABLE);
        end
        default: begin
          if (sp_load) begin
            next_s.sp = sp_wdata[`SSM_SP_W-1:0];
          end
          if (pc_advance) begin
            if (s.boot == ssm_pkg::SSM_BOOT) begin
              next_s.boot = ssm_pkg::SSM_RUN;
              next_s.pc = test_mode ? 16'(s.pc + 16'h0001) : `SSM_USER_START;
            end else begin
              next_s.pc = 16'(s.pc + 16'h0001);
            end
          end
          // Data access through a pointer, stack traffic has priority
          if (dp_rd) begin
            next_s.rdata = byte_mode ? {8'h00, (dpa[0] ? wword[15:8] : wword[7:0])} : wword;
          end
          if (dp_wr) begin
            if (!byte_mode) begin
              next_s.mem[wi] = dp_wdata;
            end else if (dpa[0]) begin
              next_s.mem[wi] = {dp_wdata[7:0], wword[7:0]};
            end else begin
              next_s.mem[wi] = {wword[15:8], dp_wdata[7:0]};
            end
          end
          if (dp_load) begin
            next_s.dp[dp_sel] = dp_wval;
          end else if ((dp_rd || dp_wr) && dp_step == `SSM_STEP_INC) begin
            next_s.dp[dp_sel] = 16'(dpa + 16'h0001);
          end else if ((dp_rd || dp_wr) && dp_step == `SSM_STEP_DEC) begin
            next_s.dp[dp_sel] = 16'(dpa - 16'h0001);
          end
        end
      endcase
      if (acc_we) begin
        next_s.acc[acc_widx] = acc_wdata;
      end
      next_s.acc_rdata = s.acc[acc_ridx];
      next_s.rom_sel = in_rom(next_s.pc);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.boot <= ssm_pkg::SSM_BOOT;
      s.pc <= `SSM_ROM_BASE;
      s.rom_sel <= 1'b1;
      s.sp <= `SSM_SP_TOP;
    end else begin
      s <= next_s;
    end
  end

  assign stack_top_pointer           = s.sp;
  assign prog_addr                   = s.pc;
  assign rom_sel                     = s.rom_sel;
  assign pop_data                    = s.pop_data;
  assign pop_with_interrupt_reenable = s.reen;
  assign data_addr                   = s.dp[dp_sel];
  assign data_rdata                  = s.rdata;
  assign acc_rdata                   = s.acc_rdata;

  // First enabled program step while still in the boot phase
  assign boot_step = ce && pc_advance && op == ssm_pkg::SSM_OP_NONE && s.boot == ssm_pkg::SSM_BOOT;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_SP_RESET: assert property ($past(rst) |-> s.sp == `SSM_SP_TOP)
    else $error("stack pointer not at top after reset");
  AST_PUSH_DEC: assert property (ce && op == ssm_pkg::SSM_OP_PUSH |=> s.sp == `SSM_SP_W'($past(s.sp) - 1'b1))
    else $error("push did not decrement stack pointer");
  AST_POP_INC: assert property (ce && op == ssm_pkg::SSM_OP_POP |=> s.sp == `SSM_SP_W'($past(s.sp) + 1'b1))
    else $error("pop did not increment stack pointer");
  AST_CALL_RET: assert property (ce && op == ssm_pkg::SSM_OP_CALL ##1 ce && op == ssm_pkg::SSM_OP_RET
    |=> s.pc == 16'($past(s.pc, 2) + 16'h0001))
    else $error("return did not restore call address");
  AST_PUSH_POP: assert property (ce && op == ssm_pkg::SSM_OP_PUSH ##1 ce && op == ssm_pkg::SSM_OP_POP_WITH_INTERRUPT_REENABLE
    |=> pop_data == $past(push_data, 2) && pop_with_interrupt_reenable)
    else $error("popped value differs from pushed value");
  AST_ROM_MAP: assert property (rom_sel == in_rom(prog_addr))
    else $error("rom select disagrees with program address");
  AST_BOOT_FETCH: assert property ($past(rst) |-> prog_addr == `SSM_ROM_BASE)
    else $error("fetch did not start in utility rom after reset");
  AST_BOOT: assert property (boot_step && !test_mode |=> prog_addr == `SSM_USER_START)
    else $error("boot did not branch to user start");
  AST_BOOT_TEST: assert property (boot_step && test_mode |=> prog_addr == 16'(`SSM_ROM_BASE + 16'h0001))
    else $error("test mode boot left the utility rom");
  AST_DP_INC: assert property (ce && op == ssm_pkg::SSM_OP_NONE && dp_rd && !dp_load
    && dp_step == `SSM_STEP_INC ##1 1'b1 |-> s.dp[$past(dp_sel)] == 16'($past(s.dp[dp_sel]) + 16'h0001))
    else $error("data pointer did not increment");
  AST_ACC_RW: assert property (ce && acc_we ##1 ce && !acc_we && acc_ridx == $past(acc_widx)
    |=> acc_rdata == $past(acc_wdata, 2))
    else $error("working register read-back mismatch");

  COV_CALL_RET: cover property (ce && op == ssm_pkg::SSM_OP_CALL ##[1:4] ce && op == ssm_pkg::SSM_OP_RET);
  COV_INT_RETURN_FROM_INTERRUPT: cover property (ce && op == ssm_pkg::SSM_OP_INT ##[1:4] ce && op == ssm_pkg::SSM_OP_RETURN_FROM_INTERRUPT);
  COV_BYTE_WR:  cover property (ce && op == ssm_pkg::SSM_OP_NONE && dp_wr && byte_mode);

endmodule // ssm_core
`default_nettype wire

//--- ssm_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_seq_model (
  input  wire logic              mclk,
  input  wire logic              reen,
  output var ssm_pkg::ssm_op_t   op,
  output var logic [15:0]        target,
  output var logic [15:0]        int_vector,
  output var logic [15:0]        push_data,
  output var logic               reen_seen
);
  initial begin
    op = ssm_pkg::SSM_OP_NONE;
    target = 16'h0000;
    int_vector = 16'h0000;
    push_data = 16'h0000;
    reen_seen = 1'b0;
  end
  // One op, operands held over the taking edge, then scrambled
  task automatic issue(input ssm_pkg::ssm_op_t o, input logic [15:0] v);
    op = o;
    target = v;
    int_vector = v;
    push_data = v;
    @(negedge mclk);
    reen_seen = reen;
    op = ssm_pkg::SSM_OP_NONE;
    target = ~v;
    int_vector = ~v;
    push_data = ~v;
    @(negedge mclk);
  endtask
  // Two ops on back-to-back edges, then one idle cycle
  task automatic issue2(input ssm_pkg::ssm_op_t o1, input logic [15:0] v1,
                        input ssm_pkg::ssm_op_t o2, input logic [15:0] v2);
    op = o1;
    target = v1;
    int_vector = v1;
    push_data = v1;
    @(negedge mclk);
    op = o2;
    target = v2;
    int_vector = v2;
    push_data = v2;
    @(negedge mclk);
    reen_seen = reen;
    op = ssm_pkg::SSM_OP_NONE;
    target = ~v2;
    int_vector = ~v2;
    push_data = ~v2;
    @(negedge mclk);
  endtask
endmodule // ssm_seq_model
`default_nettype wire

//--- soft_stack_memory_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssm_regs.svh"
module soft_stack_memory_map_bench;
  logic                 mclk, rst, ce, sp_load, pc_advance, dp_load, dp_rd, dp_wr, acc_we;
  logic [15:0]          sp_wdata, dp_wval, dp_wdata, acc_wdata, target, int_vector, push_data;
  logic [15:0]          prog_addr, pop_data, data_addr, data_rdata, acc_rdata;
  logic [1:0]           dp_step, dp_sel;
  logic [3:0]           acc_widx, acc_ridx;
  logic                 test_mode, byte_mode;
  logic [`SSM_SP_W-1:0] stack_top_pointer;
  logic                 rom_sel, reen;
  ssm_pkg::ssm_op_t     op;
  int                   failures, n_checks;
  always #2 mclk = ~mclk;
  ssm_seq_model seq (.mclk, .reen, .op, .target, .int_vector, .push_data, .reen_seen());
  ssm_core uut (.mclk, .rst, .ce, .op, .target, .int_vector, .push_data, .sp_load, .sp_wdata,
    .pc_advance, .test_mode, .dp_sel, .dp_load, .dp_wval, .dp_rd, .dp_wr,
    .byte_mode, .dp_wdata, .dp_step, .acc_we, .acc_widx, .acc_wdata,
    .acc_ridx, .stack_top_pointer, .prog_addr, .rom_sel, .pop_data,
    .pop_with_interrupt_reenable(reen), .data_addr, .data_rdata, .acc_rdata);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_boot;
    chk({6'h00, stack_top_pointer}, 16'h03FF);
    chk(prog_addr, 16'h8000);
    chk({15'h0000, rom_sel}, 16'h0001);
    ce = 1'b0;
    pc_advance = 1'b1;
    step;
    chk(prog_addr, 16'h8000);
    ce = 1'b1;
    step;
    pc_advance = 1'b0;
    chk(prog_addr, 16'h0000);
    chk({15'h0000, rom_sel}, 16'h0000);
  endtask
  task automatic t_stack;
    seq.issue(ssm_pkg::SSM_OP_PUSH, 16'h1234);
    seq.issue(ssm_pkg::SSM_OP_PUSH, 16'hABCD);
    chk({6'h00, stack_top_pointer}, 16'h03FD);
    seq.issue(ssm_pkg::SSM_OP_POP, 16'h0000);
    chk(pop_data, 16'hABCD);
    chk({6'h00, stack_top_pointer}, 16'h03FE);
    seq.issue(ssm_pkg::SSM_OP_POP_WITH_INTERRUPT_REENABLE, 16'h0000);
    chk(pop_data, 16'h1234);
    chk({15'h0000, seq.reen_seen}, 16'h0001);
    chk({15'h0000, reen}, 16'h0000);
  endtask
  task automatic t_flow;
    seq.issue(ssm_pkg::SSM_OP_CALL, 16'h0100);
    chk(prog_addr, 16'h0100);
    chk({6'h00, stack_top_pointer}, 16'h03FE);
    seq.issue(ssm_pkg::SSM_OP_RET, 16'h0000);
    chk(prog_addr, 16'h0001);
    chk({15'h0000, seq.reen_seen}, 16'h0000);
    seq.issue(ssm_pkg::SSM_OP_INT, 16'h0200);
    chk(prog_addr, 16'h0200);
    seq.issue(ssm_pkg::SSM_OP_RETURN_FROM_INTERRUPT, 16'h0000);
    chk(prog_addr, 16'h0001);
    chk({15'h0000, seq.reen_seen}, 16'h0001);
    chk({6'h00, stack_top_pointer}, 16'h03FF);
    seq.issue2(ssm_pkg::SSM_OP_CALL, 16'h0300, ssm_pkg::SSM_OP_RET, 16'h0000);
    chk(prog_addr, 16'h0002);
    chk({6'h00, stack_top_pointer}, 16'h03FF);
    seq.issue2(ssm_pkg::SSM_OP_PUSH, 16'h4242, ssm_pkg::SSM_OP_POP_WITH_INTERRUPT_REENABLE, 16'h0000);
    chk(pop_data, 16'h4242);
    chk({15'h0000, seq.reen_seen}, 16'h0001);
    ce = 1'b0;
    seq.issue(ssm_pkg::SSM_OP_PUSH, 16'h9999);
    ce = 1'b1;
    chk({6'h00, stack_top_pointer}, 16'h03FF);
    chk(prog_addr, 16'h0002);
  endtask
  task automatic t_wrap_data;
    sp_load = 1'b1;
    step;
    sp_load = 1'b0;
    chk({6'h00, stack_top_pointer}, 16'h0000);
    seq.issue(ssm_pkg::SSM_OP_PUSH, 16'h5555);
    chk({6'h00, stack_top_pointer}, 16'h03FF);
    dp_load = 1'b1;
    step;
    dp_load = 1'b0;
    dp_rd = 1'b1;
    dp_step = `SSM_STEP_INC;
    acc_we = 1'b1;
    acc_wdata = 16'h7777;
    step;
    dp_rd = 1'b0;
    acc_we = 1'b0;
    chk(data_rdata, 16'h5555);
    chk(data_addr, 16'h0001);
    step;
    chk(acc_rdata, 16'h7777);
    acc_ridx = 4'h9;
    step;
    chk(acc_rdata, 16'h0000);
  endtask
  task automatic t_reboot;
    test_mode = 1'b1;
    rst = 1'b1;
    repeat (2) step;
    rst = 1'b0;
    chk({6'h00, stack_top_pointer}, 16'h03FF);
    chk(prog_addr, 16'h8000);
    chk(pop_data, 16'h0000);
    pc_advance = 1'b1;
    step;
    chk(prog_addr, 16'h8001);
    repeat (766) step;
    chk(prog_addr, 16'h82FF);
    chk({15'h0000, rom_sel}, 16'h0001);
    step;
    pc_advance = 1'b0;
    chk(prog_addr, 16'h8300);
    chk({15'h0000, rom_sel}, 16'h0000);
    test_mode = 1'b0;
  endtask
  task automatic t_bytes;
    dp_sel = 2'h1;
    dp_load = 1'b1;
    dp_wval = 16'h0005;
    step;
    dp_load = 1'b0;
    dp_wr = 1'b1;
    byte_mode = 1'b1;
    dp_wdata = 16'h33A5;
    dp_step = `SSM_STEP_DEC;
    step;
    chk(data_addr, 16'h0004);
    dp_wdata = 16'hFF3C;
    dp_step = `SSM_STEP_NONE;
    step;
    dp_wr = 1'b0;
    dp_rd = 1'b1;
    dp_step = `SSM_STEP_INC;
    step;
    chk(data_rdata, 16'h003C);
    dp_step = `SSM_STEP_DEC;
    step;
    chk(data_rdata, 16'h00A5);
    chk(data_addr, 16'h0004);
    dp_rd = 1'b0;
    dp_sel = 2'h0;
    dp_load = 1'b1;
    dp_wval = 16'h0002;
    step;
    dp_load = 1'b0;
    dp_rd = 1'b1;
    byte_mode = 1'b0;
    dp_step = `SSM_STEP_NONE;
    step;
    dp_rd = 1'b0;
    chk(data_rdata, 16'hA53C);
  endtask
  initial begin
    mclk = 1'b0;
    {rst, ce, sp_load, pc_advance, dp_load, dp_rd, dp_wr, acc_we} = 8'hC0;
    {sp_wdata, dp_wval, dp_wdata, acc_wdata} = 64'h0;
    dp_step = 2'h0;
    {test_mode, byte_mode, dp_sel} = 4'h0;
    {acc_widx, acc_ridx} = 8'h33;
    failures = 0;
    n_checks = 0;
    repeat (3) step;
    rst = 1'b0;
    t_boot;
    t_stack;
    t_flow;
    t_wrap_data;
    t_reboot;
    t_bytes;
    wrap_up;
  end
  initial begin
    #100000;
    failures++;
    wrap_up;
  end
endmodule // soft_stack_memory_map_bench
`default_nettype wire
